// ### rtl/imsa_core.v
// masking, special mask mode and pci line steering of the legacy pair,
// plus the 24-input source map and pick of the advanced controller.
// assumes: inputs synchronous to clk; acknowledge and end-of-service
// strobes come from the rest of the legacy controller; the message bus
// serialiser outside takes adv_msg_* and answers with adv_bus_won.
`timescale 1ns/10ps
`include "imsa_regs.vh"

// How it works
// - mask command word loads per-channel mask
// - master cascade mask blocks slave requests
// - in-service bit holds off lower priorities
// - special mask mode ignores in-service bits
// - mode word select and enable set mode
// - pci lines steer to legal legacy inputs
// - route registers at 60h-63h, 68h-6Bh
// - several pci lines may share input
// - disable setting steers a line nowhere
// - pci lines active low, inverted inward
// - routed input refuses serial link requests
// - advanced controller has 24 vectored inputs
// - advanced priority independent of input number
// - advanced delivery by message, no acknowledge
// - win bus arbitration before each message
// - inputs 0,2,8,13 fed internally only
// - inputs 16-19 take lines a-d
// - inputs 20-23 take lines e-h
// - edge on rise, level while high
module imsa_core #(
  parameter NPIRQ = 8,
  parameter NADV  = 24
) (
  // clock, enable and reset
  input  wire              clk,
  input  wire              ce,
  input  wire              rst_b,
  // register writes
  input  wire              cfg_wr,
  input  wire [7:0]        cfg_addr,
  input  wire [31:0]       cfg_wdata,
  input  wire              mcw_wr_m,
  input  wire              mcw_wr_s,
  input  wire [7:0]        mask_command_word,
  input  wire [7:0]        mode_command_word,
  input  wire [15:0]       edge_level_select,
  // service strobes from the legacy sequencer
  input  wire              ack_m,
  input  wire              ack_s,
  input  wire              eos_m,
  input  wire              eos_s,
  // request sources
  input  wire [NPIRQ-1:0]  pci_irq_lines_b,
  input  wire [15:0]       serial_irq_link,
  input  wire [15:0]       other_irq,
  input  wire              pit_irq,
  input  wire              rtc_irq,
  input  wire              fpu_error_input_b,
  input  wire              audio_irq,
  input  wire              usb2_irq,
  input  wire [3:0]        pci_msg_eh,
  // advanced controller programming
  input  wire [NADV-1:0]   adv_enable,
  input  wire [NADV*4-1:0] adv_prio,
  input  wire              adv_bus_won,
  // results
  output reg  [31:0]       route_ad_reg,
  output reg  [31:0]       route_eh_reg,
  output reg  [7:0]        channel_mask_m_reg,
  output reg  [7:0]        channel_mask_s_reg,
  output reg  [7:0]        in_service_m_reg,
  output reg  [7:0]        in_service_s_reg,
  output reg               cpu_int_reg,
  output reg  [2:0]        best_m_reg,
  output reg               adv_msg_req_reg,
  output reg  [4:0]        adv_msg_in_reg
);

  reg        special_mask_m_reg;
  reg        special_mask_s_reg;
  reg [15:0] irq_d_reg;
  reg [15:0] pend_reg;
  reg [NADV-1:0] adv_pend_reg;

  // route bytes as one flat vector, byte n belongs to pci line n
  wire [63:0] route_bytes = {route_eh_reg, route_ad_reg};

  // steering: each enabled route byte with a legal code drives one input.
  // the same pass marks the inputs that pci has taken from the serial
  // link, so one route byte decides both and they cannot disagree
  reg  [15:0] pci_to_irq;
  reg  [15:0] claimed;
  reg  [7:0]  rbyte;
  reg         legal;
  integer i;
  always @* begin
    pci_to_irq = 16'h0000;
    claimed = 16'h0000;
    rbyte = 8'h00;
    legal = 1'b0;
    for (i = 0; i < NPIRQ; i = i + 1) begin
      rbyte = route_bytes[i*8 +: 8];
      // only the legacy inputs that pci may reach are legal codes
      case (rbyte[3:0])
        4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hA, 4'hB, 4'hC,
        4'hE, 4'hF: legal = 1'b1;
        default: legal = 1'b0;
      endcase
      // a disabled or refused code leaves the line unrouted
      if (legal && !rbyte[`IMSA_ROUTE_DIS_BIT]) begin
        claimed[rbyte[3:0]] = 1'b1;
        if (!pci_irq_lines_b[i])
          pci_to_irq[rbyte[3:0]] = 1'b1;
      end
    end
  end

  // legacy input levels: steered pci, other sources, unclaimed serial
  wire [15:0] irq_level = pci_to_irq | other_irq
                        | (serial_irq_link & ~claimed);

  // edge or level capture; hardware set wins over service clear
  wire [15:0] raw_req = (edge_level_select & irq_level)
                      | (~edge_level_select & irq_level & ~irq_d_reg);

  // is software's: routed inputs are expected level-selected.
  // a level bit falls with its input, an edge bit stays until served
  wire [15:0] held_level = pend_reg & edge_level_select & irq_level;
  wire [15:0] held_edge  = pend_reg & ~edge_level_select;
  wire [15:0] req        = held_level | held_edge | raw_req;

  // slave then master resolution: mask, then in-service hold-off unless special
  function [3:0] pick;
    input [7:0] r;
    input [7:0] in_service_bits;
    input       special_mask_enable;
    integer j;
    reg done;
    begin
      pick = 4'h8;
      done = 1'b0;
      for (j = 0; j < 8; j = j + 1) begin
        if (!done && !special_mask_enable && in_service_bits[j]) done = 1'b1;
        if (!done && r[j]) begin
          pick = j[3:0];
          done = 1'b1;
        end
      end
    end
  endfunction

  wire [7:0] req_s = req[15:8] & ~channel_mask_s_reg;
  wire [3:0] win_s = pick(req_s, in_service_s_reg, special_mask_s_reg);
  wire [7:0] req_m0 = req[7:0] | ((win_s[3] == 1'b0) ? 8'h04 : 8'h00);
  wire [7:0] req_m = req_m0 & ~channel_mask_m_reg;
  wire [3:0] win_m = pick(req_m, in_service_m_reg, special_mask_m_reg);

  // acknowledge takes the current winner: one-hot masks that drop its
  // pending bit and set its service bit
  wire [15:0] ack_clr_m = (ack_m && !win_m[3])
                        ? (16'h0001 << win_m[2:0]) : 16'h0000;
  wire [15:0] ack_clr_s = (ack_s && !win_s[3])
                        ? (16'h0100 << win_s[2:0]) : 16'h0000;
  wire [7:0]  isr_set_m = ack_clr_m[7:0];
  wire [7:0]  isr_set_s = ack_clr_s[15:8];
  // end of service clears the lowest-numbered set bit, which is the
  // highest priority level now in service
  wire [7:0]  isr_low_m  = in_service_m_reg & (in_service_m_reg - 8'h01);
  wire [7:0]  isr_low_s  = in_service_s_reg & (in_service_s_reg - 8'h01);
  wire [7:0]  isr_kept_m = eos_m ? isr_low_m : in_service_m_reg;
  wire [7:0]  isr_kept_s = eos_s ? isr_low_s : in_service_s_reg;
  // a fresh raw request refills a pending bit in the acknowledge cycle
  wire [15:0] pend_next  = (req & ~ack_clr_m & ~ack_clr_s) | raw_req;

  // route registers, written by configuration cycles
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      route_ad_reg <= {4{`IMSA_ROUTE_RST}};
      route_eh_reg <= {4{`IMSA_ROUTE_RST}};
    end else if (ce) begin
      if (cfg_wr && cfg_addr == `IMSA_ROUTE_AD_OFS)
        route_ad_reg <= cfg_wdata;
      if (cfg_wr && cfg_addr == `IMSA_ROUTE_EH_OFS)
        route_eh_reg <= cfg_wdata;
    end
  end

  // channel masks and special mask mode of both controllers
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      channel_mask_m_reg <= 8'hFF;
      channel_mask_s_reg <= 8'hFF;
      special_mask_m_reg <= 1'b0;
      special_mask_s_reg <= 1'b0;
    end else if (ce) begin
      if (mcw_wr_m) channel_mask_m_reg <= mask_command_word;
      if (mcw_wr_s) channel_mask_s_reg <= mask_command_word;
      // mode bit only moves when its select bit comes with the strobe
      if (mcw_wr_m && mode_command_word[`IMSA_MCW_SPECIAL_MASK_SELECT_BIT])
        special_mask_m_reg <= mode_command_word[`IMSA_MCW_SMM_BIT];
      if (mcw_wr_s && mode_command_word[`IMSA_MCW_SPECIAL_MASK_SELECT_BIT])
        special_mask_s_reg <= mode_command_word[`IMSA_MCW_SMM_BIT];
    end
  end

  // request capture and service bits; acknowledge set beats eos clear
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_d_reg <= 16'h0000;
      pend_reg <= 16'h0000;
      in_service_m_reg <= 8'h00;
      in_service_s_reg <= 8'h00;
    end else if (ce) begin
      irq_d_reg <= irq_level;
      pend_reg <= pend_next;
      in_service_m_reg <= isr_kept_m | isr_set_m;
      in_service_s_reg <= isr_kept_s | isr_set_s;
    end
  end

  // processor interrupt and winning master input
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cpu_int_reg <= 1'b0;
      best_m_reg <= 3'h0;
    end else if (ce) begin
      cpu_int_reg <= ~win_m[3];
      best_m_reg <= win_m[2:0];
    end
  end

  // advanced controller source map, 24 inputs
  wire [NADV-1:0] adv_src;
  // inputs fed only from inside: cascade, timer, clock, fpu error
  assign adv_src[0] = ~win_m[3];                  // cascade output
  assign adv_src[`IMSA_ADV_PIT_IN] = pit_irq;
  assign adv_src[`IMSA_ADV_RTC_IN] = rtc_irq;
  assign adv_src[`IMSA_ADV_FPU_IN] = ~fpu_error_input_b;
  // isa inputs reached over the serial link
  assign adv_src[1] = serial_irq_link[1];
  assign adv_src[7:3] = serial_irq_link[7:3];
  assign adv_src[12:9] = serial_irq_link[12:9];
  // the two inputs that also come straight from pins
  assign adv_src[15:14] = serial_irq_link[15:14] | other_irq[15:14];
  // pci lines a-d, audio shares input 17
  assign adv_src[19:16] = ~pci_irq_lines_b[3:0]
                        | {2'b00, audio_irq, 1'b0};
  // pci lines e-h or pci messages, never serial; usb on input 23
  assign adv_src[23:20] = ~pci_irq_lines_b[7:4] | pci_msg_eh
                        | {usb2_irq, 3'b000};

  // pick highest programmed priority among pending enabled inputs
  reg [4:0] adv_best;
  reg [3:0] adv_bp;
  reg       adv_any;
  integer n;
  always @* begin
    adv_best = 5'h00;
    adv_bp = 4'h0;
    adv_any = 1'b0;
    for (n = 0; n < NADV; n = n + 1) begin
      if (adv_pend_reg[n] && adv_enable[n]
          && (!adv_any || adv_prio[n*4 +: 4] > adv_bp)) begin
        adv_best = n[4:0];
        adv_bp = adv_prio[n*4 +: 4];
        adv_any = 1'b1;
      end
    end
  end

  // the input whose message has just won the bus
  wire            adv_sent = adv_msg_req_reg && adv_bus_won;
  wire [NADV-1:0] adv_clr  = adv_sent
                           ? ({{(NADV-1){1'b0}}, 1'b1} << adv_msg_in_reg)
                           : {NADV{1'b0}};

  // pending inputs; a still active source refills its bit at once
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      adv_pend_reg <= {NADV{1'b0}};
    end else if (ce) begin
      adv_pend_reg <= (adv_pend_reg & ~adv_clr) | adv_src;
    end
  end

  // message request held until bus won, so nothing goes out unarbitrated
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      adv_msg_req_reg <= 1'b0;
      adv_msg_in_reg <= 5'h00;
    end else if (ce) begin
      if (adv_sent)
        adv_msg_req_reg <= 1'b0; // no acknowledge cycle
      else if (!adv_msg_req_reg && adv_any) begin
        adv_msg_req_reg <= 1'b1;
        adv_msg_in_reg <= adv_best;
      end
    end
  end

endmodule

// ### pkg/imsa_regs.vh
// constants for the interrupt mask, steering and advanced-input map block
// assumes plain verilog-2005 includes by bare name
`ifndef IMSA_REGS_VH
`define IMSA_REGS_VH
// configuration byte addresses of the route registers
`define IMSA_ROUTE_AD_OFS  8'h60
`define IMSA_ROUTE_EH_OFS  8'h68
// route byte layout: bit 7 disables, bits 3:0 pick the legacy input
`define IMSA_ROUTE_DIS_BIT 7
`define IMSA_ROUTE_RST     8'h80
// mode command word bits
`define IMSA_MCW_SMM_BIT   5
`define IMSA_MCW_SPECIAL_MASK_SELECT_BIT  6
// fixed legacy and advanced input numbers
`define IMSA_CASCADE_IN    3'h2
`define IMSA_ADV_PIT_IN    5'h02
`define IMSA_ADV_RTC_IN    5'h08
`define IMSA_ADV_FPU_IN    5'h0D
`define IMSA_ADV_PCI_AD    5'h10
`define IMSA_ADV_PCI_EH    5'h14
`define IMSA_ADV_AUDIO_IN  5'h11
`define IMSA_ADV_USB2_IN   5'h17
`endif

// ### tb/imsa_core_monitor.sv
// assertions on the mask, steering and advanced pick ports
// assumes one clock domain; bound onto imsa_core at the foot
`timescale 1ns/10ps
module imsa_core_monitor (
  // inputs of the core
  input logic        clk,
  input logic        ce,
  input logic        rst_b,
  input logic        cfg_wr,
  input logic [7:0]  cfg_addr,
  input logic [31:0] cfg_wdata,
  input logic        mcw_wr_m,
  input logic [7:0]  mask_command_word,
  input logic        ack_m,
  input logic        eos_m,
  input logic        adv_bus_won,
  // outputs of the core
  input logic [31:0] route_ad_reg,
  input logic [31:0] route_eh_reg,
  input logic [7:0]  channel_mask_m_reg,
  input logic [7:0]  in_service_m_reg,
  input logic        cpu_int_reg,
  input logic [2:0]  best_m_reg,
  input logic        adv_msg_req_reg,
  input logic [4:0]  adv_msg_in_reg
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // a taken route write, and a master that is fully masked
  sequence s_wr(a);
    ce && cfg_wr && cfg_addr == a;
  endsequence
  sequence s_shut;
    ce && channel_mask_m_reg == 8'hFF;
  endsequence
  a_route_reset: assert property ($rose(rst_b) |->
    route_ad_reg == 32'h80808080 && route_eh_reg == 32'h80808080)
    else $error("route reset value wrong");
  a_route_ad_write: assert property (s_wr(8'h60) |=>
    route_ad_reg == $past(cfg_wdata)) else $error("route a-d not loaded");
  a_route_eh_write: assert property (s_wr(8'h68) |=>
    route_eh_reg == $past(cfg_wdata)) else $error("route e-h not loaded");
  a_mask_load: assert property (ce && mcw_wr_m |=>
    channel_mask_m_reg == $past(mask_command_word))
    else $error("master mask not loaded");
  a_masked_quiet: assert property (s_shut [*3] |-> !cpu_int_reg)
    else $error("interrupt while fully masked");
  a_ack_in_service: assert property (ce && ack_m && !eos_m && cpu_int_reg
    |=> in_service_m_reg[$past(best_m_reg)])
    else $error("acknowledge did not set in-service");
  a_eos_clears: assert property (ce && eos_m && !ack_m
    && in_service_m_reg != 8'h00 |=> $countones(in_service_m_reg) + 1
    == $countones($past(in_service_m_reg))) else $error("eos not one bit");
  a_msg_stands: assert property (adv_msg_req_reg && !(ce && adv_bus_won)
    |=> adv_msg_req_reg) else $error("message request dropped early");
  a_msg_in_range: assert property (adv_msg_req_reg |->
    adv_msg_in_reg < 5'h18) else $error("message input out of range");
endmodule
bind imsa_core imsa_core_monitor imsa_core_monitor_i (.clk, .ce, .rst_b,
  .cfg_wr, .cfg_addr, .cfg_wdata, .mcw_wr_m, .mask_command_word, .ack_m,
  .eos_m, .adv_bus_won, .route_ad_reg, .route_eh_reg, .channel_mask_m_reg,
  .in_service_m_reg, .cpu_int_reg, .best_m_reg, .adv_msg_req_reg,
  .adv_msg_in_reg);

// ### tb/imsa_src_model.sv
// model of pci devices sharing active-low interrupt lines
// assumes the bench asks for a line by setting its bit in raise
`timescale 1ns/10ps
module imsa_src_model (
  // clock and requests from the bench
  input  logic       clk,
  input  logic [7:0] raise,
  // shared lines, pulled up while released
  output logic [7:0] pci_irq_lines_b
);
  // a device pulls its line low and holds it while asking
  initial pci_irq_lines_b = 8'hFF;
  always @(posedge clk) pci_irq_lines_b <= ~raise;
endmodule

// ### tb/irq_mask_steer_advanced_irq_controller_map_tb.sv
// bench for masking, steering and the advanced input map
// assumes imsa_core and imsa_src_model; inputs move 1 ns after the edge
`timescale 1ns/10ps
module irq_mask_steer_advanced_irq_controller_map_tb;
  localparam [24:0] ADV_MAP = {5'h17, 5'h11, 5'h0D, 5'h08, 5'h02};
  reg         clk = 1'h0, rst_b = 1'h0, cfg_wr = 1'h0, ack_m = 1'h0;
  reg         mcw_wr_m = 1'h0, mcw_wr_s = 1'h0, eos_m = 1'h0;
  reg         adv_bus_won = 1'h0, ce = 1'h1;
  reg  [7:0]  cfg_addr = 8'h00, raise = 8'h00, mask_command_word = 8'h00;
  reg  [7:0]  mode_command_word = 8'h00;
  reg  [31:0] cfg_wdata = 32'h0;
  reg  [15:0] edge_level_select = 16'h0, serial_irq_link = 16'h0;
  reg  [15:0] other_irq = 16'h0;
  reg  [4:0]  misc = 5'h00;
  reg  [23:0] adv_enable = 24'h0;
  reg  [95:0] adv_prio = {12'h0, 4'hF, 12'h0, 4'h1, 64'h0};
  wire [31:0] route_ad_reg, route_eh_reg;
  wire [7:0]  channel_mask_m_reg, in_service_m_reg, pci_irq_lines_b;
  wire [4:0]  adv_msg_in_reg;
  wire [2:0]  best_m_reg;
  wire        cpu_int_reg, adv_msg_req_reg;
  integer     n_mismatch = 0, compares = 0, i;
  // 40 MHz clock
  always #12.5 clk = ~clk;
  imsa_core imsa_core_i (.clk, .ce, .rst_b, .cfg_wr, .cfg_addr,
    .cfg_wdata, .mcw_wr_m, .mcw_wr_s, .mask_command_word,
    .mode_command_word, .edge_level_select, .ack_m, .ack_s(1'h0), .eos_m,
    .eos_s(1'h0), .pci_irq_lines_b, .serial_irq_link, .other_irq,
    .pit_irq(misc[0]), .rtc_irq(misc[1]), .fpu_error_input_b(~misc[2]),
    .audio_irq(misc[3]), .usb2_irq(misc[4]), .pci_msg_eh(4'h0), .adv_enable,
    .adv_prio, .adv_bus_won, .route_ad_reg, .route_eh_reg,
    .channel_mask_m_reg, .channel_mask_s_reg(), .in_service_m_reg,
    .in_service_s_reg(), .cpu_int_reg, .best_m_reg, .adv_msg_req_reg,
    .adv_msg_in_reg);
  imsa_src_model imsa_src_model_i (.clk, .raise, .pci_irq_lines_b);
  // wait n edges, then move off the edge
  task step(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one route register write
  task cfg_w(input [7:0] a, input [31:0] d);
    cfg_addr = a;
    cfg_wdata = d;
    cfg_wr = 1'h1;
    step(1);
    cfg_wr = 1'h0;
    step(1);
  endtask
  // mask and mode word write to master (m=1) or slave, then settle
  task mcw(input m, input [7:0] mask, input [7:0] mode);
    mask_command_word = mask;
    mode_command_word = mode;
    mcw_wr_m = m;
    mcw_wr_s = !m;
    step(1);
    mcw_wr_m = 1'h0;
    mcw_wr_s = 1'h0;
    step(3);
  endtask
  // compare a result against its expected value
  task chk(input [63:0] what, input [31:0] exp, input [31:0] got);
    compares = compares + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("ERROR %0s expected %h seen %h", what, exp, got);
    end
  endtask
  // verdict and end of run
  task results;
    if (n_mismatch == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    #20000 n_mismatch = n_mismatch + 1;
    results;
  end
  // main sequence
  initial begin
    step(12);
    rst_b = 1'h1;
    chk("route_ad", 32'h80808080, route_ad_reg);
    chk("mask_m", 32'hFF, channel_mask_m_reg);
    // a write while the clock enable is low must not land
    ce = 1'h0;
    cfg_w(8'h60, 32'h03030303);
    chk("route_ad", 32'h80808080, route_ad_reg);
    ce = 1'h1;
    // lines a,b share input 3, c gets refused code 8, d disabled
    cfg_w(8'h60, 32'h85080303);
    cfg_w(8'h68, 32'h0F0E0A09);
    chk("route_ad", 32'h85080303, route_ad_reg);
    chk("route_eh", 32'h0F0E0A09, route_eh_reg);
    edge_level_select = 16'hFFFF;
    serial_irq_link = 16'h0008;
    mcw(1'h0, 8'h00, 8'h00);
    raise = 8'h04;
    mcw(1'h1, 8'h00, 8'h00);
    chk("cpu_int", 0, cpu_int_reg);
    raise = 8'h02;
    step(4);
    chk("cpu_int", 1, cpu_int_reg);
    chk("best_m", 3, best_m_reg);
    ack_m = 1'h1;
    step(1);
    ack_m = 1'h0;
    raise = 8'h00;
    chk("isr_m", 8'h08, in_service_m_reg);
    other_irq = 16'h0020;
    step(4);
    chk("cpu_int", 0, cpu_int_reg);
    mcw(1'h1, 8'h00, 8'h60);
    chk("cpu_int", 1, cpu_int_reg);
    chk("best_m", 5, best_m_reg);
    mcw(1'h1, 8'h00, 8'h40);
    chk("cpu_int", 0, cpu_int_reg);
    eos_m = 1'h1;
    step(1);
    eos_m = 1'h0;
    step(3);
    chk("isr_m", 0, in_service_m_reg);
    chk("cpu_int", 1, cpu_int_reg);
    mcw(1'h1, 8'h20, 8'h00);
    chk("cpu_int", 0, cpu_int_reg);
    other_irq = 16'h0200;
    mcw(1'h1, 8'h04, 8'h00);
    chk("cpu_int", 0, cpu_int_reg);
    mcw(1'h1, 8'h00, 8'h00);
    chk("best_m", 2, best_m_reg);
    // internal sources land on their fixed advanced inputs
    for (i = 0; i < 5; i = i + 1) begin
      adv_enable = 24'h1 << ADV_MAP[i*5 +: 5];
      misc = 5'h01 << i;
      step(4);
      chk("msg_in", ADV_MAP[i*5 +: 5], adv_msg_in_reg);
      chk("msg_req", 1, adv_msg_req_reg);
      // source drops before the win so its pending bit is not refilled
      misc = 5'h00;
      adv_bus_won = 1'h1;
      step(1);
      adv_bus_won = 1'h0;
      step(1);
      chk("msg_req", 0, adv_msg_req_reg);
      step(2);
    end
    // input 20 set above input 16 outranks it
    adv_enable = 24'h110000;
    raise = 8'h11;
    step(5);
    chk("msg_in", 5'h14, adv_msg_in_reg);
    results;
  end
endmodule
